// file: hdl/shrm_pkg.sv
// ============================================================
// safe homing reference monitor: shared constants
`default_nettype none
package shrm_pkg;
    // ========================================================
    // clock and timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned ONE_SECOND_NS = 1_000_000_000;
    localparam int unsigned CLK_PER_S = ONE_SECOND_NS / CLK_PERIOD_NS;
    localparam logic [31:0] INTERVAL_S_RST = 32'h0000_0e10;

    // ========================================================
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_REF2_POS = 8'h04;
    localparam logic [7:0] ADDR_REF1_POS = 8'h08;
    localparam logic [7:0] ADDR_TOL = 8'h0c;
    localparam logic [7:0] ADDR_MAX_VEL = 8'h10;
    localparam logic [7:0] ADDR_INTERVAL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

    // ========================================================
    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_COUPLE_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_ERRSEL_BIT = 4;
    localparam int CTRL_CYCLIC_BIT = 5;
    localparam int CTRL_SPECIAL_BIT = 6;
    localparam int CTRL_START_BIT = 8;
    localparam logic [6:0] CTRL_RST = 7'h10;

    // ========================================================
    // status fields
    localparam int ST_VALID_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_MISSING_BIT = 2;
    localparam int ST_ERROR_BIT = 3;
    localparam int ST_WARN_BIT = 4;
    localparam int ST_OVERSPEED_BIT = 5;
    localparam int ST_LEVEL_BIT = 6;
    localparam int ST_DIAG_LSB = 16;

    // ========================================================
    // interrupt bits
    localparam int IRQ_W = 5;
    localparam int IRQ_ESTAB_BIT = 0;
    localparam int IRQ_CHECK_OK_BIT = 1;
    localparam int IRQ_EXPIRED_BIT = 2;
    localparam int IRQ_FAIL_BIT = 3;
    localparam int IRQ_OVERSPEED_BIT = 4;

    // ========================================================
    // diagnostics
    localparam logic [15:0] DIAG_MISSING = 16'h3112;
    localparam logic [1:0] DIAG_CLASS_NONE = 2'h0;
    localparam logic [1:0] DIAG_CLASS_WARN = 2'h1;
    localparam logic [1:0] DIAG_CLASS_ERR = 2'h2;

    typedef enum logic [1:0] {
        EVAL_STATIC,
        EVAL_RISE,
        EVAL_FALL,
        EVAL_STATIC_ALT
    } shrm_eval_t;
endpackage
`default_nettype wire

// file: hdl/shrm_ref_if.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// second reference signal as seen by the monitor core
interface shrm_ref_if;
    logic level;
    logic event_hit;
    modport src (output level, output event_hit);
    modport dst (input level, input event_hit);
endinterface
`default_nettype wire

// file: hdl/shrm_ref_eval.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// home switch synchroniser and edge or level evaluation
module shrm_ref_eval (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic home_sw_i,
    input wire shrm_pkg::shrm_eval_t mode_i,
    shrm_ref_if.src ref_o
);
    import shrm_pkg::*;

    logic s1_q, s2_q, s3_q, lvl_q, lvl_d1_q;
    wire logic agree = (s2_q == s3_q);
    wire logic rise = lvl_q & ~lvl_d1_q;
    wire logic fall = ~lvl_q & lvl_d1_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
            lvl_d1_q <= 1'b0;
        end else if (ce_i) begin
            s1_q <= home_sw_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a change counts only once two stages agree
            if (agree) begin
                lvl_q <= s3_q;
            end
            lvl_d1_q <= lvl_q;
        end
    end

    assign ref_o.level = lvl_q;
    // static mode qualifies every cycle the switch stays active
    assign ref_o.event_hit = (mode_i == EVAL_RISE) ? rise :
                             (mode_i == EVAL_FALL) ? fall : lvl_q;
endmodule // shrm_ref_eval
`default_nettype wire

// file: hdl/shrm_interval_timer.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// reference check interval timer, one second resolution
module shrm_interval_timer #(
    parameter int unsigned CLK_PER_S = shrm_pkg::CLK_PER_S
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic [31:0] interval_s_i,
    output logic expired_o
);
    import shrm_pkg::*;

    logic [31:0] pre_q, sec_q;
    logic exp_q;
    wire logic tick = (pre_q == 32'(CLK_PER_S - 1));
    wire logic [31:0] sec_inc = sec_q + 32'h0000_0001;
    wire logic last = tick & (sec_inc >= interval_s_i);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_q <= 32'h0;
            sec_q <= 32'h0;
            exp_q <= 1'b0;
        end else if (ce_i) begin
            if (!run_i || restart_i) begin
                pre_q <= 32'h0;
                sec_q <= 32'h0;
                exp_q <= 1'b0;
            end else begin
                pre_q <= tick ? 32'h0 : pre_q + 32'h0000_0001;
                sec_q <= last ? 32'h0 : (tick ? sec_inc : sec_q);
                exp_q <= last;
            end
        end
    end

    assign expired_o = exp_q;
endmodule // shrm_interval_timer
`default_nettype wire

// file: hdl/shrm_top.sv
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// safe homing reference monitor, wishbone classic slave
module shrm_top #(
    parameter int unsigned CLK_PER_S = shrm_pkg::CLK_PER_S
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic home_sw_i,
    input wire logic drive_homing_command_i,
    input wire logic first_ref_i,
    input wire logic signed [31:0] pos_act_i,
    input wire logic signed [31:0] vel_act_i,
    output logic safe_ref_valid_o,
    output logic safe_homing_command_o,
    output logic speed_limit_active_o,
    output logic [31:0] speed_limit_o,
    output logic overspeed_o,
    output logic ref_error_o,
    output logic ref_warning_o,
    output logic [15:0] diag_code_o,
    output logic [1:0] diag_class_o,
    output logic irq_o
);
    import shrm_pkg::*;

    // ========================================================
    // helpers
    // saturates, so a far position never wraps into range
    function automatic logic [31:0] abs_diff(input logic signed [31:0] a,
                                             input logic signed [31:0] b);
        logic signed [32:0] d;
        d = 33'(a) - 33'(b);
        if (d < 0) begin
            d = -d;
        end
        abs_diff = (d[32] || d[31]) ? 32'hffff_ffff : d[31:0];
    endfunction

    // byte-lane merge for every writable register but the interrupt mask and interrupt status
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // ========================================================
    // reset release
    // release two edges late, clear of recovery time
    logic [1:0] rst_sync_q;
    wire logic rst_b = rst_sync_q[1];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // ========================================================
    // registers
    logic [6:0] ctrl_q;
    logic [31:0] ref2_q, ref1_q, tol_q, max_vel_q, interval_q;
    logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_set;
    logic ack_q;
    logic [31:0] dat_q;

    // writes land on the edge where ack is sampled
    wire logic req = wb_cyc_i & wb_stb_i;
    wire logic wr_en = req & wb_we_i & ack_q;
    wire logic [7:0] adr_w = {wb_adr_i[7:2], 2'h0};
    wire logic hit_ctrl = (adr_w == ADDR_CTRL);
    wire logic hit_ref2 = (adr_w == ADDR_REF2_POS);
    wire logic hit_ref1 = (adr_w == ADDR_REF1_POS);
    wire logic hit_tol = (adr_w == ADDR_TOL);
    wire logic hit_vel = (adr_w == ADDR_MAX_VEL);
    wire logic hit_int = (adr_w == ADDR_INTERVAL);
    wire logic hit_stat = (adr_w == ADDR_STATUS);
    wire logic hit_istat = (adr_w == ADDR_IRQ_STAT);
    wire logic hit_imask = (adr_w == ADDR_IRQ_MASK);

    wire logic [31:0] ctrl_wr = merge({25'h0, ctrl_q}, wb_dat_i, wb_sel_i);
    wire logic sw_start = wr_en & hit_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_START_BIT];
    wire logic [IRQ_W-1:0] irq_clr = (wr_en & hit_istat & wb_sel_i[0]) ?
                                     wb_dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}};

    wire logic en = ctrl_q[CTRL_EN_BIT];
    wire logic couple = ctrl_q[CTRL_COUPLE_BIT];
    wire shrm_eval_t eval_mode = shrm_eval_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
    wire logic err_sel = ctrl_q[CTRL_ERRSEL_BIT];
    wire logic cyclic = ctrl_q[CTRL_CYCLIC_BIT];
    wire logic special = ctrl_q[CTRL_SPECIAL_BIT];

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
            ref2_q <= 32'h0;
            ref1_q <= 32'h0;
            tol_q <= 32'h0;
            max_vel_q <= 32'h0;
            interval_q <= INTERVAL_S_RST;
            irq_mask_q <= {IRQ_W{1'b0}};
        end else if (ce_i && wr_en) begin
            if (hit_ctrl) begin
                ctrl_q <= ctrl_wr[6:0];
            end
            if (hit_ref2) begin
                ref2_q <= merge(ref2_q, wb_dat_i, wb_sel_i);
            end
            if (hit_ref1) begin
                ref1_q <= merge(ref1_q, wb_dat_i, wb_sel_i);
            end
            if (hit_tol) begin
                tol_q <= merge(tol_q, wb_dat_i, wb_sel_i);
            end
            if (hit_vel) begin
                max_vel_q <= merge(max_vel_q, wb_dat_i, wb_sel_i);
            end
            if (hit_int) begin
                interval_q <= merge(interval_q, wb_dat_i, wb_sel_i);
            end
            if (hit_imask && wb_sel_i[0]) begin
                irq_mask_q <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // ========================================================
    // second reference input
    // the core sees only the synchronised switch
    shrm_ref_if ref_bus ();

    shrm_ref_eval u_eval (
        .clk_i(clk_i),
        .rst_b_i(rst_b),
        .ce_i(ce_i),
        .home_sw_i(home_sw_i),
        .mode_i(eval_mode),
        .ref_o(ref_bus.src)
    );

    // ========================================================
    // homing command sequence
    typedef enum logic {
        HM_IDLE,
        HM_SEEK
    } shrm_hm_t;

    // no seek timeout: clearing enable ends a stuck search
    shrm_hm_t hm_q, hm_d;
    logic valid_q, valid_d, seen1_q, seen1_d, seen2_q, seen2_d;
    logic over_q;

    wire logic [31:0] dev1 = abs_diff(pos_act_i, $signed(ref1_q));
    wire logic [31:0] dev2 = abs_diff(pos_act_i, $signed(ref2_q));
    wire logic [31:0] vel_abs = abs_diff(vel_act_i, 32'sh0);
    wire logic in_tol1 = (dev1 <= tol_q);
    wire logic in_tol2 = (dev2 <= tol_q);
    wire logic slow = (vel_abs < max_vel_q);
    wire logic start = en & (sw_start | (couple & drive_homing_command_i));
    wire logic ref_hit = ref_bus.dst.event_hit;
    wire logic chk_ok = valid_q & cyclic & ref_hit & slow & in_tol2;
    wire logic expired;
    wire logic fail1 = first_ref_i & ~in_tol1;
    wire logic fail2 = ref_hit & ~in_tol2;
    wire logic done = (seen1_q | first_ref_i) & (seen2_q | ref_hit) & ~fail1 & ~fail2;

    always_comb begin
        hm_d = hm_q;
        valid_d = valid_q;
        seen1_d = seen1_q;
        seen2_d = seen2_q;
        irq_set = {IRQ_W{1'b0}};
        if (!en) begin
            hm_d = HM_IDLE;
            valid_d = 1'b0;
            seen1_d = 1'b0;
            seen2_d = 1'b0;
        end else begin
            case (hm_q)
                HM_IDLE: begin
                    if (start) begin
                        hm_d = HM_SEEK;
                        valid_d = 1'b0;
                        seen1_d = 1'b0;
                        seen2_d = 1'b0;
                    end else if (expired) begin
                        valid_d = 1'b0;
                        irq_set[IRQ_EXPIRED_BIT] = 1'b1;
                    end else if (chk_ok) begin
                        irq_set[IRQ_CHECK_OK_BIT] = 1'b1;
                    end
                end
                HM_SEEK: begin
                    seen1_d = seen1_q | first_ref_i;
                    seen2_d = seen2_q | ref_hit;
                    if (fail1 || fail2) begin
                        hm_d = HM_IDLE;
                        irq_set[IRQ_FAIL_BIT] = 1'b1;
                    end else if (done) begin
                        hm_d = HM_IDLE;
                        valid_d = 1'b1;
                        irq_set[IRQ_ESTAB_BIT] = 1'b1;
                    end
                end
                default: begin
                    hm_d = HM_IDLE;
                end
            endcase
        end
        irq_set[IRQ_OVERSPEED_BIT] = overspeed_o & ~over_q;
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            hm_q <= HM_IDLE;
            valid_q <= 1'b0;
            seen1_q <= 1'b0;
            seen2_q <= 1'b0;
            over_q <= 1'b0;
        end else if (ce_i) begin
            hm_q <= hm_d;
            valid_q <= valid_d;
            seen1_q <= seen1_d;
            seen2_q <= seen2_d;
            over_q <= overspeed_o;
        end
    end

    // ========================================================
    // cyclic reference check timer
    // runs only with a reference; success restarts it
    shrm_interval_timer #(
        .CLK_PER_S(CLK_PER_S)
    ) u_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b),
        .ce_i(ce_i),
        .run_i(valid_q & cyclic & en),
        .restart_i(chk_ok | start),
        .interval_s_i(interval_q),
        .expired_o(expired)
    );

    // ========================================================
    // reporting
    // special mode forces the error class
    wire logic missing = en & ~valid_q;
    wire logic is_err = missing & (err_sel | special);
    wire logic is_warn = missing & ~is_err;

    assign safe_ref_valid_o = valid_q;
    assign safe_homing_command_o = (hm_q == HM_SEEK);
    // the limit is advisory: the drive's velocity loop must clamp to it
    assign speed_limit_active_o = missing;
    assign speed_limit_o = missing ? max_vel_q : 32'hffff_ffff;
    assign overspeed_o = missing & (vel_abs > max_vel_q);
    assign ref_error_o = is_err;
    assign ref_warning_o = is_warn;
    assign diag_code_o = missing ? DIAG_MISSING : 16'h0;
    assign diag_class_o = is_err ? DIAG_CLASS_ERR :
                          (is_warn ? DIAG_CLASS_WARN : DIAG_CLASS_NONE);

    // ========================================================
    // interrupts: set wins over a simultaneous clear
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    assign irq_o = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_q <= {IRQ_W{1'b0}};
        end else if (ce_i) begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // ========================================================
    // bus answer
    // ack and read data come from flops: one wait state
    wire logic [31:0] status_w = {DIAG_MISSING & {16{missing}}, 9'h0,
                                  ref_bus.dst.level, overspeed_o, is_warn,
                                  is_err, missing, safe_homing_command_o, valid_q};
    wire logic [31:0] rd_mux = hit_ctrl ? {25'h0, ctrl_q} :
                               hit_ref2 ? ref2_q :
                               hit_ref1 ? ref1_q :
                               hit_tol ? tol_q :
                               hit_vel ? max_vel_q :
                               hit_int ? interval_q :
                               hit_stat ? status_w :
                               hit_istat ? {27'h0, irq_stat_q} :
                               hit_imask ? {27'h0, irq_mask_q} : 32'h0;

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else if (ce_i) begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                dat_q <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule // shrm_top
`default_nettype wire

// file: dv/shrm_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// port-level checks of the reference monitor
module shrm_asserts (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic signed [31:0] vel_act_i,
    input wire logic safe_ref_valid_o,
    input wire logic safe_homing_command_o,
    input wire logic speed_limit_active_o,
    input wire logic [31:0] speed_limit_o,
    input wire logic overspeed_o,
    input wire logic ref_error_o,
    input wire logic ref_warning_o,
    input wire logic [15:0] diag_code_o,
    input wire logic [1:0] diag_class_o
);
    import shrm_pkg::*;
    // unsigned magnitude: the most negative velocity still maps correctly
    logic [31:0] vel_mag;
    assign vel_mag = vel_act_i[31] ? 32'(-vel_act_i) : 32'(vel_act_i);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus answer late");
    property p_no_limit;
        safe_ref_valid_o |-> !speed_limit_active_o && speed_limit_o == 32'hffffffff;
    endproperty
    a_no_limit: assert property (p_no_limit) else $error("limit with reference");
    property p_overspeed;
        overspeed_o == (speed_limit_active_o && vel_mag > speed_limit_o);
    endproperty
    a_overspeed: assert property (p_overspeed) else $error("overspeed flag wrong");
    property p_report;
        ref_error_o || ref_warning_o |-> speed_limit_active_o && !(ref_error_o && ref_warning_o);
    endproperty
    a_report: assert property (p_report) else $error("report state wrong");
    property p_diag_err;
        ref_error_o |-> diag_code_o == DIAG_MISSING && diag_class_o == DIAG_CLASS_ERR;
    endproperty
    a_diag_err: assert property (p_diag_err) else $error("error code wrong");
    property p_diag_warn;
        ref_warning_o |-> diag_code_o == DIAG_MISSING && diag_class_o == DIAG_CLASS_WARN;
    endproperty
    a_diag_warn: assert property (p_diag_warn) else $error("warning code wrong");
    property p_diag_none;
        !ref_error_o && !ref_warning_o |-> diag_class_o == DIAG_CLASS_NONE;
    endproperty
    a_diag_none: assert property (p_diag_none) else $error("class without report");
    property p_valid_src;
        $rose(safe_ref_valid_o) |-> $past(safe_homing_command_o);
    endproperty
    a_valid_src: assert property (p_valid_src) else $error("valid without homing");
    property p_seek_clear;
        safe_homing_command_o |-> !safe_ref_valid_o;
    endproperty
    a_seek_clear: assert property (p_seek_clear) else $error("valid during homing");
endmodule // shrm_asserts
bind shrm_top shrm_asserts u_chk (.*);
`default_nettype wire

// file: dv/shrm_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// home switch and drive homing control
module shrm_partner (
    input wire logic clk_i,
    output logic home_sw_o,
    output logic drv_cmd_o,
    output logic first_ref_o,
    output logic signed [31:0] pos_o,
    output logic signed [31:0] vel_o
);
    initial begin
        {home_sw_o, drv_cmd_o, first_ref_o} = 3'h0;
        pos_o = 32'h0;
        vel_o = 32'h0;
    end
    // steady contact, never pulsed for testing; waits out the synchroniser
    task automatic set_sw(input logic lvl);
        @(posedge clk_i);
        home_sw_o <= lvl;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic move(input logic signed [31:0] p, input logic signed [31:0] v);
        @(posedge clk_i);
        pos_o <= p;
        vel_o <= v;
    endtask
    // one-cycle strobe: drive homing start or first reference found
    task automatic pulse(input logic drv);
        @(posedge clk_i);
        if (drv) drv_cmd_o <= 1'b1;
        else first_ref_o <= 1'b1;
        @(posedge clk_i);
        drv_cmd_o <= 1'b0;
        first_ref_o <= 1'b0;
    endtask
endmodule // shrm_partner
`default_nettype wire

// file: dv/shrm_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// self-checking bench of the reference monitor
module shrm_top_bench;
    import shrm_pkg::*;
    localparam logic [31:0] REF1 = 32'h64, REF2 = 32'h1f4, TOL = 32'ha, VMAX = 32'h32;
    localparam logic [31:0] EN = 32'h1, CPL = 32'h2, ERR = 32'h10, CYC = 32'h20;
    localparam logic [31:0] SPC = 32'h40, GO = 32'h100;
    logic clk_i = 1'b0, rst_b_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, q, rdat, lim;
    logic ack, valid, cmd, lim_act, ovs, err, warn, irq, sw, dcmd, fref;
    logic signed [31:0] pos, vel;
    logic [15:0] diag;
    logic [1:0] cls;
    int err_count = 0, comparisons = 0, cycles = 0;
    always #50 clk_i = ~clk_i;
    shrm_partner far (.clk_i(clk_i), .home_sw_o(sw), .drv_cmd_o(dcmd), .first_ref_o(fref),
        .pos_o(pos), .vel_o(vel));
    shrm_top #(.CLK_PER_S(10)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .home_sw_i(sw),
        .drive_homing_command_i(dcmd), .first_ref_i(fref), .pos_act_i(pos), .vel_act_i(vel),
        .safe_ref_valid_o(valid), .safe_homing_command_o(cmd), .speed_limit_active_o(lim_act),
        .speed_limit_o(lim), .overspeed_o(ovs), .ref_error_o(err), .ref_warning_o(warn),
        .diag_code_o(diag), .diag_class_o(cls), .irq_o(irq));
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            wrap_up;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ack is sampled on the rising edge; one wait state
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        chk("wb_ack_wait", 32'h2, 32'(n));
        {cyc, stb} <= 2'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic t_reset;
        rd(ADDR_CTRL, 32'h10, "ctrl");
        rd(ADDR_INTERVAL, 32'he10, "interval");
        rd(ADDR_IRQ_MASK, 32'h0, "irq_mask");
        rd(8'h24, 32'h0, "unmapped");
        sel <= 4'h1;
        wb(1'b1, ADDR_TOL, 32'h1234_56ff);
        sel <= 4'hf;
        rd(ADDR_TOL, 32'hff, "tol_lane");
        wb(1'b1, ADDR_CTRL, GO | ERR);
        repeat (3) @(negedge clk_i);
        chk("homing_cmd", 32'h0, 32'(cmd));
        chk("limit_active", 32'h0, 32'(lim_act));
        chk("error", 32'h0, 32'(err));
        $display("test reset done");
    endtask
    task automatic t_missing;
        wb(1'b1, ADDR_CTRL, EN);
        @(negedge clk_i);
        chk("warning", 32'h1, 32'(warn));
        chk("class", 32'h1, 32'(cls));
        chk("code", 32'h3112, 32'(diag));
        chk("limit", VMAX, lim);
        far.move(32'h0, -(VMAX + 1));
        @(negedge clk_i);
        chk("overspeed", 32'h1, 32'(ovs));
        far.move(32'h0, VMAX);
        @(negedge clk_i);
        chk("no_overspeed", 32'h0, 32'(ovs));
        wb(1'b1, ADDR_CTRL, EN | SPC);
        @(negedge clk_i);
        chk("special_error", 32'h1, 32'(err));
        wb(1'b1, ADDR_CTRL, EN | ERR);
        @(negedge clk_i);
        chk("error_class", 32'h2, 32'(cls));
        $display("test missing done");
    endtask
    // idle level is the opposite of the level that makes the event
    task automatic t_home(input logic [1:0] md, input logic cpl);
        int n;
        far.set_sw(md == 2'h2);
        wb(1'b1, ADDR_CTRL, EN | ERR | CYC | (32'(md) << 2) | (cpl ? CPL : GO));
        if (cpl) far.pulse(1'b1);
        @(negedge clk_i);
        chk("busy", 32'h1, 32'(cmd));
        far.move(REF1 + TOL, 32'h0);
        far.pulse(1'b0);
        far.move(REF2 - TOL, 32'h0);
        far.set_sw(md != 2'h2);
        for (n = 0; n < 20 && valid !== 1'b1; n++) @(negedge clk_i);
        chk("valid", 32'h1, 32'(valid));
        chk("busy_done", 32'h0, 32'(cmd));
        $display("test homing mode %0d done", md);
    endtask
    task automatic t_tol;
        int n;
        far.set_sw(1'b0);
        wb(1'b1, ADDR_IRQ_STAT, 32'h1f);
        wb(1'b1, ADDR_CTRL, EN | ERR | GO);
        far.move(REF1 - TOL, 32'h0);
        far.pulse(1'b0);
        far.move(REF2 + TOL + 1, 32'h0);
        far.set_sw(1'b1);
        for (n = 0; n < 20 && cmd !== 1'b0; n++) @(negedge clk_i);
        chk("busy", 32'h0, 32'(cmd));
        chk("valid", 32'h0, 32'(valid));
        rd(ADDR_IRQ_STAT, 32'h8, "irq_fail");
        $display("test tolerance done");
    endtask
    task automatic t_cyclic;
        int n;
        wb(1'b1, ADDR_INTERVAL, 32'h5);
        t_home(2'h1, 1'b0);
        chk("irq_masked", 32'h0, 32'(irq));
        wb(1'b1, ADDR_IRQ_STAT, 32'h1f);
        wb(1'b1, ADDR_IRQ_MASK, 32'h2);
        far.set_sw(1'b0);
        far.move(REF2, VMAX - 1);
        far.set_sw(1'b1);
        chk("check_ok", 32'h1, 32'(irq));
        wb(1'b1, ADDR_IRQ_STAT, 32'h2);
        far.set_sw(1'b0);
        far.move(REF2, VMAX);
        far.set_sw(1'b1);
        chk("check_slow", 32'h0, 32'(irq));
        chk("still_valid", 32'h1, 32'(valid));
        @(posedge clk_i);
        ce <= 1'b0;
        repeat (100) @(posedge clk_i);
        chk("frozen_valid", 32'h1, 32'(valid));
        ce <= 1'b1;
        wb(1'b1, ADDR_IRQ_MASK, 32'h4);
        for (n = 0; n < 80 && valid !== 1'b0; n++) @(negedge clk_i);
        chk("expired", 32'h0, 32'(valid));
        chk("irq_expired", 32'h1, 32'(irq));
        chk("error", 32'h1, 32'(err));
        rd(ADDR_IRQ_STAT, 32'h4, "irq_stat");
        $display("test cyclic done");
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_reset;
        wb(1'b1, ADDR_REF1_POS, REF1);
        wb(1'b1, ADDR_REF2_POS, REF2);
        wb(1'b1, ADDR_TOL, TOL);
        wb(1'b1, ADDR_MAX_VEL, VMAX);
        t_missing;
        for (int m = 0; m < 4; m++) t_home(2'(m), m[0]);
        t_tol;
        t_cyclic;
        wrap_up;
    end
endmodule // shrm_top_bench
`default_nettype wire
